// >>> verilog/bus_master_unit.v
// Single-wire bus master: slot engine and identifier selection commands.
// Assumes a line pull-up and a same-clock user.
`timescale 1ns/1ps

`include "bus_master_defs.vh"

// What this block does
// R1: Long reset gives standard speed; overdrive only by selection.
// R2: Same slots at both speeds; widths from speed field.
// R3: Long reset gives standard; short keeps overdrive.
// R4: Read-id 33h, search F0h, select-all CCh.
// R5: Resume byte is A5h.
// R6: Selection 55h or 69h, then identifier LSB first.
// R7: Slaves drop at first identifier mismatch.
// R8: Overdrive selection at standard, then overdrive.
// R9: Overdrive select-all 3Ch at standard, then overdrive.
// R10: Select-all activates every slave.
// R11: Deselected slaves idle until reset.
// R12: 64-bit identifier, type code bits 0-7.
// R13: Bits 8-55 hold the serial.
// R14: Bits 56-63 hold CRC x^8+x^5+x^4+1.
// R15: Read-id answer: eight bytes, type first.
// R16: Identifier CRC mismatch flags collision.
// R17: Search: read, complement, write chosen bit.
// R18: Search runs bit 0 to 63.
// R19: Search runs at the current speed, overdrive included.
// R20: LSB first; one direction at a time.
// R21: Slot timing from a 1 MHz tick.
// R22: CRC of first 56 bits against last byte.
module bus_master_unit (
    input  wire        clk,
    input  wire        arst_n,
    input  wire [7:0]  microsecond_tick_divisor,
    input  wire        high_speed_select,
    input  wire        cmd_valid,
    output wire        cmd_ready,
    input  wire [3:0]  cmd_op,
    input  wire [7:0]  cmd_data,
    input  wire [63:0] cmd_id,
    input  wire [63:0] cmd_path,
    output wire        rd_valid,
    input  wire        rd_ready,
    output wire [7:0]  rd_data,
    input  wire        ow_in,
    output wire        ow_out,
    output wire        ow_oe,
    output wire        busy,
    output wire        done,
    output wire        presence,
    output wire        crc_error,
    output wire        search_fail,
    output wire        high_speed
);
    // ====
    // Sequencer states
    localparam S_IDLE = 4'h0;
    localparam S_RST  = 4'h1;
    localparam S_CMD  = 4'h2;
    localparam S_IDW  = 4'h3;
    localparam S_IDR  = 4'h4;
    localparam S_SRCH = 4'h5;
    localparam S_DR   = 4'h6;
    localparam S_PUSH = 4'h7;
    localparam S_END  = 4'h8;

    // ====
    // Slot width lookups
    function [9:0] t_low;
        input od;
        input rst;
        input bitv;
        t_low = rst ? (od ? `OD_RST_LOW : `STD_RST_LOW) :
                bitv ? (od ? `OD_W1_LOW : `STD_W1_LOW) : (od ? `OD_W0_LOW : `STD_W0_LOW);
    endfunction

    function [9:0] t_smp;
        input od;
        input rst;
        t_smp = rst ? (od ? `OD_RST_SMP : `STD_RST_SMP) : (od ? `OD_SMP : `STD_SMP);
    endfunction

    function [9:0] t_end;
        input od;
        input rst;
        t_end = rst ? (od ? `OD_RST_END : `STD_RST_END) : (od ? `OD_SLOT_END : `STD_SLOT_END);
    endfunction

    function [7:0] rom_code;
        input [3:0] op;
        begin
            case (op)
                `OP_READ_ID:  rom_code = `CODE_READ_ID;  // [R4]
                `OP_SEARCH:   rom_code = `CODE_SEARCH;   // [R4]
                `OP_SKIP:     rom_code = `CODE_SKIP;     // [R4]
                `OP_MATCH:    rom_code = `CODE_MATCH;    // [R6]
                `OP_OD_MATCH: rom_code = `CODE_OD_MATCH; // [R6]
                `OP_OD_SKIP:  rom_code = `CODE_OD_SKIP;  // [R9]
                `OP_RESUME:   rom_code = `CODE_RESUME;   // [R5]
                default:      rom_code = 8'h00;
            endcase
        end
    endfunction

    // ====
    // Registers
    reg  [7:0]  div_cnt_ff;
    reg         tick_ff;
    reg         line_s1_ff;
    reg         line_s2_ff;
    reg         slot_go_ff;
    reg         slot_busy_ff;
    reg         slot_fin_ff;
    reg  [9:0]  slot_t_ff;
    reg         slot_rst_ff;
    reg         slot_bit_ff;
    reg         slot_od_ff;
    reg         slot_smp_ff;
    reg         ow_oe_ff;
    reg         ow_out_ff;
    reg  [3:0]  state_ff;
    reg  [3:0]  ret_ff;
    reg  [3:0]  op_ff;
    reg  [7:0]  sh_ff;
    reg  [63:0] id_ff;
    reg  [63:0] path_ff;
    reg  [63:0] idsh_ff;
    reg  [6:0]  bit_ff;
    reg  [1:0]  phase_ff;
    reg         a_ff;
    reg         b_ff;
    reg         wait_ff;
    reg         cmd_ready_ff;
    reg         busy_ff;
    reg         done_ff;
    reg         presence_ff;
    reg         crc_err_ff;
    reg         fail_ff;
    reg         hs_ff;

    wire [7:0]  crc_val;
    wire        buf_in_ready;
    wire        accept;
    wire        need_slot;
    wire        launch;
    wire        slot_od;
    wire        dir;
    wire        wr_bit;
    wire        crc_en;
    wire        crc_din;
    wire [9:0]  t_nxt;
    wire [7:0]  nxt_div;

    assign cmd_ready   = cmd_ready_ff;
    assign ow_out      = ow_out_ff;
    assign ow_oe       = ow_oe_ff;
    assign busy        = busy_ff;
    assign done        = done_ff;
    assign presence    = presence_ff;
    assign crc_error   = crc_err_ff;
    assign search_fail = fail_ff;
    assign high_speed  = hs_ff;

    assign accept    = cmd_valid & cmd_ready_ff;
    // Divisor of zero behaves as one
    assign nxt_div   = (microsecond_tick_divisor == 8'h00) ? 8'h00 : microsecond_tick_divisor - 8'h01;
    assign t_nxt     = slot_t_ff + 10'h001;

    // Overdrive selection bytes always go slow; search runs at the current speed
    assign slot_od   = hs_ff & (op_ff != `OP_OD_MATCH) & (op_ff != `OP_OD_SKIP); // [R8] [R9] [R19]
    assign dir       = (a_ff != b_ff) ? a_ff : path_ff[bit_ff[5:0]];              // [R17]
    assign need_slot = (state_ff == S_RST) | (state_ff == S_CMD) | (state_ff == S_IDW) |
                       (state_ff == S_IDR) | (state_ff == S_SRCH) | (state_ff == S_DR);
    assign launch    = need_slot & ~wait_ff;
    assign wr_bit    = (state_ff == S_CMD)  ? sh_ff[0] :                            // [R20]
                       (state_ff == S_IDW)  ? id_ff[bit_ff[5:0]] :                  // [R6]
                       (state_ff == S_SRCH && phase_ff == 2'h2) ? dir : 1'b1;

    assign crc_en    = slot_fin_ff & (bit_ff < `ID_CRC_START) &
                       ((state_ff == S_IDR) | ((state_ff == S_SRCH) & (phase_ff == 2'h2))); // [R22]
    assign crc_din   = (state_ff == S_IDR) ? slot_smp_ff : slot_bit_ff;

    // ====
    // Microsecond tick
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt_ff <= 8'h00;
            tick_ff    <= 1'b0;
        end
        else if (div_cnt_ff >= nxt_div)
        begin
            div_cnt_ff <= 8'h00;
            tick_ff    <= 1'b1; // [R21]
        end
        else
        begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
            tick_ff    <= 1'b0;
        end
    end

    // ====
    // Line synchroniser
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_s1_ff <= 1'b1;
            line_s2_ff <= 1'b1;
        end
        else
        begin
            line_s1_ff <= ow_in;
            line_s2_ff <= line_s1_ff;
        end
    end

    // ====
    // Slot engine: identical shape at both speeds, widths from lookups
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            slot_busy_ff <= 1'b0;
            slot_fin_ff  <= 1'b0;
            slot_t_ff    <= 10'h000;
            slot_smp_ff  <= 1'b1;
            ow_oe_ff     <= 1'b0;
            ow_out_ff    <= 1'b0;
        end
        else
        begin
            slot_fin_ff <= 1'b0;
            if (slot_go_ff)
            begin
                slot_busy_ff <= 1'b1;
                slot_t_ff    <= 10'h000;
                ow_oe_ff     <= 1'b1;
            end
            else if (slot_busy_ff && tick_ff)
            begin
                slot_t_ff <= t_nxt;
                if (t_nxt == t_low(slot_od_ff, slot_rst_ff, slot_bit_ff)) // [R2]
                    ow_oe_ff <= 1'b0;
                if (t_nxt == t_smp(slot_od_ff, slot_rst_ff))
                    slot_smp_ff <= line_s2_ff;
                if (t_nxt == t_end(slot_od_ff, slot_rst_ff))
                begin
                    slot_busy_ff <= 1'b0;
                    slot_fin_ff  <= 1'b1;
                end
            end
        end
    end

    // ====
    // Command sequencer
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff     <= S_IDLE;
            ret_ff       <= S_IDLE;
            op_ff        <= `OP_RESET;
            sh_ff        <= 8'h00;
            id_ff        <= 64'h0;
            path_ff      <= 64'h0;
            idsh_ff      <= 64'h0;
            bit_ff       <= 7'h00;
            phase_ff     <= 2'h0;
            a_ff         <= 1'b0;
            b_ff         <= 1'b0;
            wait_ff      <= 1'b0;
            slot_go_ff   <= 1'b0;
            slot_rst_ff  <= 1'b0;
            slot_bit_ff  <= 1'b1;
            slot_od_ff   <= 1'b0;
            cmd_ready_ff <= 1'b1;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            presence_ff  <= 1'b0;
            crc_err_ff   <= 1'b0;
            fail_ff      <= 1'b0;
            hs_ff        <= 1'b0;
        end
        else
        begin
            slot_go_ff <= 1'b0;
            done_ff    <= 1'b0;
            if (slot_fin_ff)
                wait_ff <= 1'b0;
            if (launch)
            begin
                slot_go_ff  <= 1'b1;
                wait_ff     <= 1'b1;
                slot_rst_ff <= (state_ff == S_RST);
                slot_bit_ff <= wr_bit;
                if (state_ff == S_RST)
                begin
                    // Short reset only keeps overdrive when already in it
                    slot_od_ff <= hs_ff & high_speed_select; // [R3]
                    hs_ff      <= hs_ff & high_speed_select; // [R1]
                end
                else
                    slot_od_ff <= slot_od;
            end
            case (state_ff)
                S_IDLE:
                begin
                    if (accept)
                    begin
                        cmd_ready_ff <= 1'b0;
                        busy_ff      <= 1'b1;
                        op_ff        <= cmd_op;
                        id_ff        <= cmd_id;
                        path_ff      <= cmd_path;
                        bit_ff       <= 7'h00;
                        phase_ff     <= 2'h0;
                        sh_ff        <= (cmd_op == `OP_WRITE) ? cmd_data : rom_code(cmd_op);
                        if (cmd_op == `OP_READ_ID || cmd_op == `OP_SEARCH)
                        begin
                            crc_err_ff <= 1'b0;
                            fail_ff    <= 1'b0;
                        end
                        if (cmd_op == `OP_RESET)
                            state_ff <= S_RST;
                        else if (cmd_op == `OP_READ)
                            state_ff <= S_DR;
                        else
                            state_ff <= S_CMD;
                    end
                end
                S_RST:
                begin
                    if (slot_fin_ff)
                    begin
                        presence_ff <= ~slot_smp_ff;
                        state_ff    <= S_END;
                    end
                end
                S_CMD:
                begin
                    if (slot_fin_ff)
                    begin
                        sh_ff   <= {1'b0, sh_ff[7:1]}; // [R20]
                        bit_ff  <= bit_ff + 7'h01;
                        if (bit_ff == 7'h07)
                        begin
                            bit_ff <= 7'h00;
                            case (op_ff)
                                `OP_MATCH, `OP_OD_MATCH: state_ff <= S_IDW; // [R6]
                                `OP_READ_ID:             state_ff <= S_IDR; // [R15]
                                `OP_SEARCH:              state_ff <= S_SRCH; // [R18]
                                default:                 state_ff <= S_END;
                            endcase
                            if (op_ff == `OP_OD_SKIP)
                                hs_ff <= 1'b1; // [R9]
                        end
                    end
                end
                S_IDW:
                begin
                    if (slot_fin_ff)
                    begin
                        bit_ff  <= bit_ff + 7'h01;
                        if (bit_ff == `ID_BITS - 7'h01)
                        begin
                            state_ff <= S_END;
                            if (op_ff == `OP_OD_MATCH)
                                hs_ff <= 1'b1; // [R8]
                        end
                    end
                end
                S_IDR, S_DR:
                begin
                    if (slot_fin_ff)
                    begin
                        idsh_ff <= {slot_smp_ff, idsh_ff[63:1]}; // [R15] [R20]
                        bit_ff  <= bit_ff + 7'h01;
                        if (bit_ff[2:0] == 3'h7)
                        begin
                            ret_ff   <= state_ff;
                            state_ff <= S_PUSH;
                        end
                    end
                end
                S_SRCH:
                begin
                    if (slot_fin_ff)
                    begin
                        case (phase_ff)
                            2'h0:
                            begin
                                a_ff     <= slot_smp_ff; // [R17]
                                phase_ff <= 2'h1;
                            end
                            2'h1:
                            begin
                                b_ff     <= slot_smp_ff;
                                phase_ff <= 2'h2;
                                // Both ones: nobody answered, no slave left
                                if (a_ff && slot_smp_ff)
                                begin
                                    fail_ff  <= 1'b1;
                                    state_ff <= S_END;
                                end
                            end
                            default:
                            begin
                                phase_ff <= 2'h0;
                                idsh_ff  <= {slot_bit_ff, idsh_ff[63:1]};
                                bit_ff   <= bit_ff + 7'h01; // [R18]
                                if (bit_ff[2:0] == 3'h7)
                                begin
                                    ret_ff   <= S_SRCH;
                                    state_ff <= S_PUSH;
                                end
                            end
                        endcase
                    end
                end
                S_PUSH:
                begin
                    // Holds here while the reader stalls
                    if (buf_in_ready)
                    begin
                        if (ret_ff == S_DR || bit_ff == `ID_BITS)
                        begin
                            state_ff <= S_END;
                            if (ret_ff != S_DR)
                                crc_err_ff <= (crc_val != idsh_ff[63:56]); // [R16] [R22]
                        end
                        else
                            state_ff <= ret_ff;
                    end
                end
                S_END:
                begin
                    done_ff      <= 1'b1;
                    busy_ff      <= 1'b0;
                    cmd_ready_ff <= 1'b1;
                    state_ff     <= S_IDLE;
                end
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    // ====
    // Submodules
    id_crc8 u_crc (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (accept),
        .en     (crc_en),
        .din    (crc_din),
        .crc    (crc_val)
    );

    read_buffer2 u_buf (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (state_ff == S_PUSH),
        .in_ready  (buf_in_ready),
        .in_data   (idsh_ff[63:56]),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );
endmodule // bus_master_unit

// >>> verilog/bus_master_defs.vh
// Constants for the single-wire bus master network layer.
// Assumes a 1 MHz microsecond tick drives every slot time.
`ifndef BUS_MASTER_DEFS_VH
`define BUS_MASTER_DEFS_VH

// ====
// Operation codes on cmd_op
`define OP_RESET      4'h0
`define OP_WRITE      4'h1
`define OP_READ       4'h2
`define OP_READ_ID    4'h3
`define OP_MATCH      4'h4
`define OP_OD_MATCH   4'h5
`define OP_SKIP       4'h6
`define OP_OD_SKIP    4'h7
`define OP_RESUME     4'h8
`define OP_SEARCH     4'h9

// ====
// Selection command bytes
`define CODE_READ_ID  8'h33
`define CODE_MATCH    8'h55
`define CODE_SEARCH   8'hF0
`define CODE_SKIP     8'hCC
`define CODE_OD_SKIP  8'h3C
`define CODE_OD_MATCH 8'h69
`define CODE_RESUME   8'hA5

// ====
// Identifier layout
`define ID_BITS       7'h40
`define ID_CRC_START  7'h38
`define CRC_REFL_POLY 8'h8C

// ====
// Slot ticks, standard
`define STD_RST_LOW   10'h1E0
`define STD_RST_SMP   10'h226
`define STD_RST_END   10'h3C0
`define STD_W0_LOW    10'h03C
`define STD_W1_LOW    10'h006
`define STD_SMP       10'h00F
`define STD_SLOT_END  10'h041

// Slot ticks, overdrive
`define OD_RST_LOW    10'h046
`define OD_RST_SMP    10'h04E
`define OD_RST_END    10'h08C
`define OD_W0_LOW     10'h008
`define OD_W1_LOW     10'h001
`define OD_SMP        10'h002
`define OD_SLOT_END   10'h00A

`endif

// >>> verilog/read_buffer2.v
// Two-entry buffer for received bytes, valid/ready on both sides.
// Assumes both sides run on clk; outputs come straight from flops.
`timescale 1ns/1ps

module read_buffer2 (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       in_valid,
    output wire       in_ready,
    input  wire [7:0] in_data,
    output wire       out_valid,
    input  wire       out_ready,
    output wire [7:0] out_data
);
    reg [7:0] head_ff;
    reg [7:0] tail_ff;
    reg       head_vld_ff;
    reg       tail_vld_ff;
    wire      push;
    wire      pop;

    assign in_ready  = ~tail_vld_ff;
    assign out_valid = head_vld_ff;
    assign out_data  = head_ff;
    assign push      = in_valid & ~tail_vld_ff;
    assign pop       = out_ready & head_vld_ff;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            head_ff     <= 8'h00;
            tail_ff     <= 8'h00;
            head_vld_ff <= 1'b0;
            tail_vld_ff <= 1'b0;
        end
        else if (pop && !push)
        begin
            head_ff     <= tail_ff;
            head_vld_ff <= tail_vld_ff;
            tail_vld_ff <= 1'b0;
        end
        else if (push && !pop)
        begin
            if (!head_vld_ff)
            begin
                head_ff     <= in_data;
                head_vld_ff <= 1'b1;
            end
            else
            begin
                tail_ff     <= in_data;
                tail_vld_ff <= 1'b1;
            end
        end
        else if (push && pop)
        begin
            if (tail_vld_ff)
            begin
                head_ff <= tail_ff;
                tail_ff <= in_data;
            end
            else
            begin
                head_ff <= in_data;
            end
        end
    end
endmodule // read_buffer2

// >>> verilog/id_crc8.v
// Serial 8-bit identifier CRC, x^8 + x^5 + x^4 + 1, lowest bit first.
// Assumes one data bit per enable pulse on clk.
`timescale 1ns/1ps

`include "bus_master_defs.vh"

module id_crc8 (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       clr,
    input  wire       en,
    input  wire       din,
    output wire [7:0] crc
);
    reg  [7:0] crc_ff;
    wire       fb;

    assign crc = crc_ff;
    assign fb  = crc_ff[0] ^ din;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            crc_ff <= 8'h00;
        else if (clr)
            crc_ff <= 8'h00;
        else if (en)
            crc_ff <= {1'b0, crc_ff[7:1]} ^ (fb ? `CRC_REFL_POLY : 8'h00); // [R14]
    end
endmodule // id_crc8

// >>> bench/bus_master_unit_properties.sv
// Port checker: speed changes, slot widths and flag holds.
// Assumes bind to the top; divisor steady during a command.
`timescale 1ns/1ps
`include "bus_master_defs.vh"
module bus_master_unit_properties (
    input wire       clk,
    input wire       arst_n,
    input wire [7:0] microsecond_tick_divisor,
    input wire       high_speed_select,
    input wire       cmd_valid,
    input wire       cmd_ready,
    input wire [3:0] cmd_op,
    input wire       ow_oe,
    input wire       busy,
    input wire       done,
    input wire       crc_error,
    input wire       search_fail,
    input wire       high_speed
);
    // ====
    // Helpers
    reg  [3:0]  op_ff;
    reg         hs_ff;
    reg  [31:0] low_ff;
    reg  [31:0] span_ff;
    wire [31:0] dv = (microsecond_tick_divisor == 8'h00) ? 32'h1 : microsecond_tick_divisor;
    wire        keep = op_ff != `OP_RESET && op_ff != `OP_OD_MATCH && op_ff != `OP_OD_SKIP;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_ff <= 4'hF; hs_ff <= 1'b0; low_ff <= 32'h0; span_ff <= 32'h0;
        end
        else
        begin
            if (cmd_valid && cmd_ready) begin op_ff <= cmd_op; hs_ff <= high_speed; end
            low_ff <= ow_oe ? low_ff + 32'h1 : 32'h0;
            span_ff <= busy ? span_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence ended(o); done && op_ff == o; endsequence
    sequence settled(b); cmd_ready && high_speed == b; endsequence
    chk_std_reset: assert property (ended(`OP_RESET) ##0 !high_speed_select |=> settled(1'b0))
        else $error("speed not standard after reset");
    chk_od_match: assert property (ended(`OP_OD_MATCH) |=> settled(1'b1))
        else $error("no overdrive after selection");
    chk_od_skip: assert property (ended(`OP_OD_SKIP) |=> settled(1'b1))
        else $error("no overdrive after select-all");
    chk_speed_kept: assert property (busy && keep |-> high_speed == hs_ff)
        else $error("speed changed by plain command");
    chk_od_width: assert property ($fell(ow_oe) && keep && hs_ff |-> low_ff <= 32'h48 * dv)
        else $error("low pulse too long at overdrive");
    chk_std_width: assert property ($fell(ow_oe) && !hs_ff |-> low_ff >= 32'h5 * dv)
        else $error("low pulse too short at standard");
    chk_match_len: assert property ($fell(busy) && op_ff[3:1] == 3'h2 && !hs_ff |-> span_ff >= 32'h1248 * dv)
        else $error("selection shorter than 72 slots");
    chk_search_len: assert property ($fell(busy) && op_ff == `OP_SEARCH && !hs_ff && !search_fail
        |-> span_ff >= 32'h30C0 * dv)
        else $error("search shorter than 192 slots");
    chk_crc_hold: assert property ($changed(crc_error) && !$past(cmd_valid && cmd_ready)
        |-> op_ff == `OP_READ_ID || op_ff == `OP_SEARCH)
        else $error("crc flag moved outside id ops");
endmodule // bus_master_unit_properties
bind bus_master_unit bus_master_unit_properties bus_master_unit_properties_inst (.*);

// >>> bench/single_wire_slave.sv
// Behavioural open-drain slave, 25 ns per tick.
// Assumes a pull-up; pull high holds the line low.
`timescale 1ns/1ps
module single_wire_slave #(parameter [63:0] ID = 64'h0) (
    input  wire      line,
    output reg       pull,
    output reg [7:0] cmd
);
    // ====
    // Slot follower
    integer m = 0, n = 0, od = 0;
    time    t0;
    reg     d, s;
    initial pull = 1'b0;
    always
    begin
        @(negedge line);
        t0 = $time;
        d = (m == 2) ? ID[n] : (m == 3 && n % 3 < 2) ? ID[n / 3] ^ (n % 3) : 1'b1;
        pull = !d;
        #(od ? 100 : 750) s = line;
        #(od ? 50 : 375) pull = 1'b0;
        wait (line);
        if ($time - t0 > 10000 || (od && $time - t0 > 1250))
        begin
            if ($time - t0 > 10000) od = 0;
            #(od ? 50 : 375) pull = 1'b1;
            #(od ? 375 : 3000) pull = 1'b0;
            m = 1; n = 0;
        end
        else if (m > 0)
        begin
            if (m == 1) cmd[n] = s;
            if ((m == 4 && s != ID[n]) || (m == 3 && n % 3 == 2 && s != ID[n / 3])) m = 0;
            n = n + 1;
            if (m == 1 && n == 8)
            begin
                m = cmd == 8'h33 ? 2 : cmd == 8'hF0 ? 3 : (cmd == 8'h55 || cmd == 8'h69) ? 4 :
                    (cmd == 8'hCC || cmd == 8'h3C) ? 5 : 0;
                od = od | (cmd == 8'h3C); n = 0;
            end
            if ((n == 64 && (m == 2 || m == 4)) || n == 192) begin od = od | (cmd == 8'h69); m = 5; end
        end
    end
endmodule // single_wire_slave

// >>> bench/tb_bus_master_unit.sv
// Bench: master against two slaves on one wire.
// Assumes divisor 1 (then 0), so one tick per clock.
`timescale 1ns/1ps
`include "bus_master_defs.vh"
module tb_bus_master_unit;
    function [7:0] crc8(input [55:0] v);
        integer q;
        begin
            crc8 = 8'h00;
            for (q = 0; q < 56; q = q + 1) crc8 = (crc8 >> 1) ^ ((crc8[0] ^ v[q]) ? 8'h8C : 8'h00);
        end
    endfunction
    localparam [55:0] LA = 56'h5AC3960F123426, LB = 56'h5AC3970F123426, TAB = 56'h335569CC3CA5F0;
    localparam [63:0] IA = {crc8(LA), LA}, IB = {crc8(LB), LB};
    reg         clk = 1'b0, arst_n = 1'b0, hss = 1'b0, cv = 1'b0, rdy = 1'b0, hold = 1'b0;
    reg  [7:0]  div = 8'h01, got[$];
    reg  [3:0]  op = 4'h0;
    reg  [63:0] path = 64'h0, x;
    wire        ready, rv, oe, out, busy, done, pres, crc_err, sfail, hs, pa, pb;
    wire [7:0]  rd, ca;
    wire        line = !((oe && !out) || pa || pb);
    integer     seed = 47, err_total = 0, comparisons = 0, k, j, i, n;
    bus_master_unit bus_master_unit_inst (.clk(clk), .arst_n(arst_n), .microsecond_tick_divisor(div),
        .high_speed_select(hss), .cmd_valid(cv), .cmd_ready(ready), .cmd_op(op), .cmd_data(8'hA5),
        .cmd_id(IA), .cmd_path(path), .rd_valid(rv), .rd_ready(rdy), .rd_data(rd), .ow_in(line),
        .ow_out(out), .ow_oe(oe), .busy(busy), .done(done), .presence(pres), .crc_error(crc_err),
        .search_fail(sfail), .high_speed(hs));
    single_wire_slave #(.ID(IA)) sa (.line(line), .pull(pa), .cmd(ca));
    single_wire_slave #(.ID(IB)) sb (.line(line), .pull(pb), .cmd());
    always #12.5 clk = ~clk;
    // ====
    // Reader that stalls at random
    always @(negedge clk)
    begin
        rdy = !hold & $random(seed);
        if (rv && rdy) got.push_back(rd);
    end
    task chk(input [63:0] g, input [63:0] e);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task run(input [3:0] o);
    begin
        @(negedge clk);
        while (ready !== 1'b1) @(negedge clk);
        op = o; cv = 1'b1;
        @(negedge clk);
        cv = 1'b0; n = 0;
        while (done !== 1'b1 && n < 60000) begin @(negedge clk); n = n + 1; end
        if (n >= 60000) err_total = err_total + 1;
        repeat (40) @(negedge clk);
    end
    endtask
    task close_out;
    begin
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    initial begin #2000000; err_total = err_total + 1; close_out; end
    initial
    begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        for (k = 3; k < 10; k = k + 1)
        begin
            if (k == 8) div = 8'h00;
            hss = 1'b0;
            run(`OP_RESET);
            chk({pres, hs}, 2'h2);
            path = {$random(seed), $random(seed)};
            got.delete();
            hold = k == 3;
            // Full buffer must pause slots, not drop bytes
            fork run(k[3:0]); if (hold) #250005 hold = 1'b0; join
            chk(ca, TAB[8 * (9 - k) +: 8]);
            chk(hs, k == 5 || k == 7);
            x = IA & IB;
            for (j = 63; j >= 0; j = j - 1) if (IA[j] != IB[j]) i = j;
            if (k == 9) x = (IA[i] == path[i]) ? IA : IB;
            if (k == 3 || k == 9)
            begin
                chk({sfail, got.size()}, 8);
                for (j = 0; j < 8; j = j + 1) chk(got[j], x[8 * j +: 8]);
                chk(crc_err, crc8(x[55:0]) !== x[63:56]);
            end
            if (k == 7)
            begin
                run(`OP_READ);
                chk(got[0], 8'hFF);
                hss = 1'b1;
                run(`OP_RESET);
                chk({pres, hs}, 2'h3);
            end
        end
        close_out;
    end
endmodule // tb_bus_master_unit
